//--- shared/brcf_pkg.sv
// Package: constants and types for the rectifier, limit and fault block
// Function
// - Low side on during commutation demag
// - Low side on when diode conducts
// - Async rectify: off near zero current
// - Limit active when measurement exceeds reference
// - Limit trip holds high side off
// - Recirculation select: brake or high-Z
// - Blank limit comparator after PWM rise
// - Internal clock re-enables at full duty
// - Refresh clock 20 or 40 kHz
// - Undervoltage: high-Z, logic off, flag latched
// - Pump undervoltage: fault, high-Z, flag latched
// - Overcurrent mode 00: latched shutdown
// - Serial error reported only when select 0
// - Trim error: latched high-Z until reset
// - Thermal shutdown: high-Z, auto resume
// - Overvoltage disabled: no action
// - Overcurrent mode 01: retry after time
// - Overcurrent mode 10: report only
// - Overcurrent mode 11: ignore
package brcf_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BLANK_NS = 1000;
  localparam int unsigned BLANK_CYC = (BLANK_NS * 25 + 999) / 1000;
  localparam int unsigned RETRY_US = 5000;
  localparam int unsigned RETRY_CYC = RETRY_US * (CLK_HZ / 1000000);
  localparam int unsigned REFRESH_20K_HZ = 20000;
  localparam int unsigned REFRESH_40K_HZ = 40000;
  localparam int unsigned REFRESH_20K_CYC = CLK_HZ / REFRESH_20K_HZ;
  localparam int unsigned REFRESH_40K_CYC = CLK_HZ / REFRESH_40K_HZ;
  localparam int unsigned CMUT_NS = 2000;
  localparam int unsigned CMUT_CYC = CMUT_NS * 25 / 1000;
  localparam logic [1:0] OCM_LATCH = 2'h0;
  localparam logic [1:0] OCM_RETRY = 2'h1;
  localparam logic [1:0] OCM_REPORT = 2'h2;
  localparam logic [1:0] OCM_OFF = 2'h3;
  localparam logic [5:0] FLAGS_RST = 6'h20;

  typedef struct packed {
    logic supply_uv;
    logic pump_uv;
    logic overcurrent;
    logic serial_err;
    logic trim_err;
    logic thermal;
    logic overvolt;
  } brcf_cond_t;

  typedef struct packed {
    logic power_on_reset_flag;
    logic pump_undervolt_flag;
    logic overcurrent_flag;
    logic serial_error_flag;
    logic thermal_shutdown_flag;
    logic overvolt_flag;
  } brcf_flags_t;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } brcf_gate_t;
endpackage : brcf_pkg

//--- design/brcf_sync.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
`default_nettype none
module brcf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= i_d;
      q_reg <= meta_reg;
    end
  end
  assign o_q = q_reg;
endmodule : brcf_sync
`default_nettype wire

//--- design/brcf_phase.sv
// One half-bridge leg: rectification gating for low side
`timescale 1ns/10ps
`default_nettype none
module brcf_phase (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Commands and sensing
  input wire logic i_pwm_hs,
  input wire logic i_pwm_ls,
  input wire logic i_demag_en,
  input wire logic i_ls_diode,
  input wire logic i_near_zero,
  // Low side request
  output logic o_ls_on
);
  logic ls_prev_reg;
  logic ls_prev_next;
  logic [6:0] cmut_reg;
  logic [6:0] cmut_next;
  logic ls_on_next;

  always_comb begin
    ls_prev_next = i_pwm_ls;
    cmut_next = cmut_reg;
    ls_on_next = i_pwm_ls;
    if (i_demag_en && ls_prev_reg && !i_pwm_ls && !i_pwm_hs && i_ls_diode)
      cmut_next = 7'(brcf_pkg::CMUT_CYC);
    else if (cmut_reg != 7'h00)
      cmut_next = cmut_reg - 7'h01;
    if (i_demag_en && !i_pwm_hs) begin
      if (i_ls_diode || cmut_reg != 7'h00)
        ls_on_next = 1'b1;
      if (i_near_zero)
        ls_on_next = 1'b0;
    end
    if (i_pwm_hs)
      ls_on_next = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ls_prev_reg <= 1'b0;
      cmut_reg <= 7'h00;
    end else begin
      ls_prev_reg <= ls_prev_next;
      cmut_reg <= cmut_next;
    end
  end
  assign o_ls_on = ls_on_next;
endmodule : brcf_phase
`default_nettype wire

//--- design/brcf_top.sv
// Top: rectification, cycle current limit and fault response
`timescale 1ns/10ps
`default_nettype none
module brcf_top #(
  parameter int unsigned RETRY_CYCLES = brcf_pkg::RETRY_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // PWM commands from controller (pins)
  input wire logic [2:0] i_pwm_hs,
  input wire logic [2:0] i_pwm_ls,
  input wire logic i_sleep_n_pin,
  // Analog comparators (pins)
  input wire logic [2:0] i_ls_diode,
  input wire logic [2:0] i_near_zero,
  input wire logic i_limit_over_ref,
  input wire brcf_pkg::brcf_cond_t i_cond,
  // Configuration
  input wire logic i_sync_rectify_enable,
  input wire logic i_async_rectify_enable,
  input wire logic i_limit_recirculation_select,
  input wire logic i_refresh_40k_sel,
  input wire logic i_pin_variant,
  input wire logic [1:0] i_overcurrent_response_mode,
  input wire logic i_serial_error_report_sel,
  input wire logic i_overvolt_protect_enable,
  input wire logic i_clear_faults_cmd,
  // Gates and status
  output brcf_pkg::brcf_gate_t o_gate,
  output brcf_pkg::brcf_flags_t o_flags,
  output logic o_fault_out_n_o,
  output logic o_fault_out_n_oe,
  output logic o_limit_active,
  output logic o_logic_enable
);
  // ==========================================================
  // Pin synchronisation
  localparam int SW = 3 + 3 + 1 + 3 + 3 + 1 + 7;
  logic [SW-1:0] raw_pins;
  logic [SW-1:0] syn_pins;
  logic [2:0] pwm_hs_s;
  logic [2:0] pwm_ls_s;
  logic sleep_n_s;
  logic sleep_s;
  logic [2:0] diode_s;
  logic [2:0] zero_s;
  logic lim_s;
  brcf_pkg::brcf_cond_t cond_s;

  // Sleep pin inverted so the flops' reset value reads as awake,
  // otherwise release of reset looks like a sleep pulse
  assign raw_pins = {i_pwm_hs, i_pwm_ls, ~i_sleep_n_pin, i_ls_diode,
                     i_near_zero, i_limit_over_ref, i_cond};
  brcf_sync #(.W(SW)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(raw_pins),
    .o_q(syn_pins)
  );
  assign {pwm_hs_s, pwm_ls_s, sleep_s, diode_s, zero_s, lim_s,
          cond_s} = syn_pins;
  assign sleep_n_s = ~sleep_s;

  // ==========================================================
  // Rectification per phase
  logic demag_en;
  logic [2:0] rect_ls;

  assign demag_en = i_sync_rectify_enable & i_async_rectify_enable;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      brcf_phase u_phase (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pwm_hs(pwm_hs_s[g]),
        .i_pwm_ls(pwm_ls_s[g]),
        .i_demag_en(demag_en),
        .i_ls_diode(diode_s[g]),
        .i_near_zero(zero_s[g]),
        .o_ls_on(rect_ls[g])
      );
    end
  endgenerate

  // ==========================================================
  // Cycle-by-cycle current limit
  logic any_pwm;
  logic pwm_prev_reg;
  logic pwm_prev_next;
  logic [5:0] blank_reg;
  logic [5:0] blank_next;
  logic [10:0] refresh_reg;
  logic [10:0] refresh_next;
  logic lim_reg;
  logic lim_next;
  logic pwm_rise;
  logic refresh_tick;
  logic [10:0] refresh_top;

  assign any_pwm = |pwm_hs_s;
  assign pwm_rise = any_pwm & ~pwm_prev_reg;
  // pin variant fixed at 20 kHz
  assign refresh_top = (i_refresh_40k_sel && !i_pin_variant) ?
                       11'(brcf_pkg::REFRESH_40K_CYC - 1) :
                       11'(brcf_pkg::REFRESH_20K_CYC - 1);
  // At or past top, so a lower top after a rate change wraps at once
  assign refresh_tick = (refresh_reg >= refresh_top);

  always_comb begin
    pwm_prev_next = any_pwm;
    blank_next = blank_reg;
    refresh_next = refresh_tick ? 11'h000 : refresh_reg + 11'h001;
    lim_next = lim_reg;
    if (pwm_rise)
      blank_next = 6'(brcf_pkg::BLANK_CYC);
    else if (blank_reg != 6'h00)
      blank_next = blank_reg - 6'h01;
    if (pwm_rise)
      lim_next = 1'b0;
    else if (refresh_tick && any_pwm)
      lim_next = 1'b0;
    if (lim_s && blank_reg == 6'h00 && !pwm_rise)
      lim_next = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_prev_reg <= 1'b0;
      blank_reg <= 6'h00;
      refresh_reg <= 11'h000;
      lim_reg <= 1'b0;
    end else begin
      pwm_prev_reg <= pwm_prev_next;
      blank_reg <= blank_next;
      refresh_reg <= refresh_next;
      lim_reg <= lim_next;
    end
  end

  // ==========================================================
  // Fault response
  typedef enum logic [2:0] {
    BRCF_RUN = 3'b001,
    BRCF_OC_LATCH = 3'b010,
    BRCF_OC_RETRY = 3'b100
  } brcf_ocst_t;

  brcf_ocst_t oc_reg;
  brcf_ocst_t oc_next;
  logic [31:0] retry_reg;
  logic [31:0] retry_next;
  brcf_pkg::brcf_flags_t flags_reg;
  brcf_pkg::brcf_flags_t flags_next;
  logic trim_reg;
  logic trim_next;
  logic sleep_prev_reg;
  logic sleep_pulse;
  logic clr;
  logic oc_ev;
  logic oc_report;
  logic hiz;
  logic fault_req;

  // Sleep reset pulse acts as a clear; trim only clears here
  assign sleep_pulse = sleep_n_s & ~sleep_prev_reg;
  assign clr = i_clear_faults_cmd | sleep_pulse;
  assign oc_ev = cond_s.overcurrent &&
                 i_overcurrent_response_mode != brcf_pkg::OCM_OFF;

  always_comb begin
    oc_next = oc_reg;
    retry_next = retry_reg;
    flags_next = flags_reg;
    trim_next = trim_reg;
    case (oc_reg)
      BRCF_RUN: begin
        if (oc_ev && i_overcurrent_response_mode == brcf_pkg::OCM_LATCH)
          oc_next = BRCF_OC_LATCH;
        else if (oc_ev &&
                 i_overcurrent_response_mode == brcf_pkg::OCM_RETRY) begin
          oc_next = BRCF_OC_RETRY;
          retry_next = RETRY_CYCLES;
        end
      end
      BRCF_OC_LATCH: begin
        if (clr && !cond_s.overcurrent)
          oc_next = BRCF_RUN;
      end
      BRCF_OC_RETRY: begin
        if (retry_reg <= 32'h1)
          oc_next = BRCF_RUN;
        else
          retry_next = retry_reg - 32'h1;
      end
      default: oc_next = BRCF_RUN;
    endcase
    if (clr) begin
      if (!cond_s.supply_uv)
        flags_next.power_on_reset_flag = 1'b0;
      if (!cond_s.pump_uv)
        flags_next.pump_undervolt_flag = 1'b0;
      if (!cond_s.overcurrent)
        flags_next.overcurrent_flag = 1'b0;
      if (!cond_s.serial_err)
        flags_next.serial_error_flag = 1'b0;
      if (!cond_s.thermal)
        flags_next.thermal_shutdown_flag = 1'b0;
      if (!cond_s.overvolt)
        flags_next.overvolt_flag = 1'b0;
    end
    if (sleep_pulse && !cond_s.trim_err)
      trim_next = 1'b0;
    // Sets placed after clears so a same-cycle event wins
    // supply undervoltage flag
    if (cond_s.supply_uv)
      flags_next.power_on_reset_flag = 1'b1;
    if (cond_s.pump_uv)
      flags_next.pump_undervolt_flag = 1'b1;
    if (oc_ev)
      flags_next.overcurrent_flag = 1'b1;
    if (cond_s.serial_err)
      flags_next.serial_error_flag = 1'b1;
    if (cond_s.thermal)
      flags_next.thermal_shutdown_flag = 1'b1;
    if (cond_s.overvolt && i_overvolt_protect_enable)
      flags_next.overvolt_flag = 1'b1;
    if (cond_s.trim_err)
      trim_next = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oc_reg <= BRCF_RUN;
      retry_reg <= 32'h0;
      flags_reg <= brcf_pkg::FLAGS_RST;
      trim_reg <= 1'b0;
      sleep_prev_reg <= 1'b1;
    end else begin
      oc_reg <= oc_next;
      retry_reg <= retry_next;
      flags_reg <= flags_next;
      trim_reg <= trim_next;
      sleep_prev_reg <= sleep_n_s;
    end
  end

  assign oc_report = flags_reg.overcurrent_flag &&
                     i_overcurrent_response_mode == brcf_pkg::OCM_REPORT;
  assign hiz = cond_s.supply_uv || cond_s.pump_uv || trim_reg ||
               cond_s.thermal || oc_reg != BRCF_RUN ||
               (cond_s.overvolt && i_overvolt_protect_enable);
  // OR of all sources except supply undervoltage; serial select
  assign fault_req = cond_s.pump_uv || trim_reg || cond_s.thermal ||
                     oc_reg != BRCF_RUN || oc_report ||
                     (cond_s.overvolt && i_overvolt_protect_enable) ||
                     (flags_reg.serial_error_flag &&
                      !i_serial_error_report_sel);

  // ==========================================================
  // Output registers
  brcf_pkg::brcf_gate_t gate_reg;
  brcf_pkg::brcf_gate_t gate_next;
  logic fault_oe_reg;
  logic logic_en_reg;

  always_comb begin
    gate_next.hs = pwm_hs_s;
    gate_next.ls = rect_ls;
    if (lim_reg) begin
      gate_next.hs = 3'h0;
      gate_next.ls = i_limit_recirculation_select ? 3'h0 : 3'h7;
    end
    if (hiz) begin
      gate_next.hs = 3'h0;
      gate_next.ls = 3'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gate_reg <= '0;
      fault_oe_reg <= 1'b0;
      logic_en_reg <= 1'b0;
    end else begin
      gate_reg <= gate_next;
      fault_oe_reg <= fault_req;
      logic_en_reg <= !cond_s.supply_uv;
    end
  end

  assign o_gate = gate_reg;
  assign o_flags = flags_reg;
  assign o_fault_out_n_o = 1'b0;
  assign o_fault_out_n_oe = fault_oe_reg;
  assign o_limit_active = lim_reg;
  assign o_logic_enable = logic_en_reg;

  // ==========================================================
  // Checks
  a_blank_no_trip: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pwm_rise |=> !lim_reg [*2])
    else $error("limit tripped during blanking");
  a_hiz_gates: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    hiz |=> gate_reg == '0)
    else $error("gates on during high-Z");
  a_limit_hs_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    lim_reg |=> gate_reg.hs == 3'h0)
    else $error("high side on during limit");
  a_brake_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    lim_reg && !hiz && !i_limit_recirculation_select |=>
    gate_reg.ls == 3'h7)
    else $error("brake mode not applied");
  a_oc_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    oc_ev && i_overcurrent_response_mode == brcf_pkg::OCM_LATCH |=>
    oc_reg == BRCF_OC_LATCH || $past(oc_reg) != BRCF_RUN)
    else $error("latched shutdown missed");
  a_fault_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fault_req |=> o_fault_out_n_oe)
    else $error("fault line not driven");
  a_ov_ignore: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_overvolt_protect_enable && !flags_reg.overvolt_flag |=>
    !flags_reg.overvolt_flag)
    else $error("overvoltage recorded while disabled");
  a_oc_ignore: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_overcurrent_response_mode == brcf_pkg::OCM_OFF && oc_reg == BRCF_RUN
    |=> oc_reg == BRCF_RUN)
    else $error("overcurrent acted in off mode");
  a_clear_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_clear_faults_cmd && !cond_s.pump_uv |=>
    !flags_reg.pump_undervolt_flag)
    else $error("pump flag not cleared");
  c_limit_trip: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !lim_reg ##1 lim_reg);
  c_retry: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    oc_reg == BRCF_OC_RETRY ##1 oc_reg == BRCF_RUN);
  c_refresh: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    lim_reg && refresh_tick && any_pwm);
endmodule : brcf_top
`default_nettype wire

//--- dv/brcf_ctrl_model.sv
// Model of the external controller that drives the PWM pins
`timescale 1ns/10ps
`default_nettype none
module brcf_ctrl_model #(
  parameter int PERIOD = 100,
  parameter int HIGH = 60,
  parameter int DEAD = 20
) (
  // Clock
  input wire logic i_clk,
  // Mode: full duty, complementary low side
  input wire logic i_full,
  input wire logic i_comp,
  // PWM pins
  output logic [2:0] o_pwm_hs = 3'h0,
  output logic [2:0] o_pwm_ls = 3'h0
);
  int cnt = 0;

  // ==========================================
  // Phase A pulsed, B and C parked off
  // Low side only in the off part, dead time before the high side
  always @(posedge i_clk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    o_pwm_hs <= {2'h0, i_full || (cnt < HIGH)};
    o_pwm_ls <= {2'h0, i_comp && !i_full && (cnt >= HIGH) &&
                 (cnt < PERIOD - DEAD)};
  end
endmodule : brcf_ctrl_model
`default_nettype wire

//--- dv/brcf_top_tb.sv
// Self-checking bench for the rectifier, limit and fault block
`timescale 1ns/10ps
`default_nettype none
module brcf_top_tb;
  localparam int unsigned RETRY = 20;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] pwm_hs;
  logic [2:0] pwm_ls;
  logic sleep_n = 1'b1, lim = 1'b0, full = 1'b1, comp = 1'b0;
  logic [2:0] ls_diode = 3'h0, near_zero = 3'h0;
  brcf_pkg::brcf_cond_t cond = '0;
  logic sr_en = 1'b0, ar_en = 1'b0, recir = 1'b0, sel40 = 1'b0;
  logic pinv = 1'b0, rep_sel = 1'b0, ov_en = 1'b0, clear = 1'b0;
  logic [1:0] ocm = 2'h0;
  brcf_pkg::brcf_gate_t gate;
  brcf_pkg::brcf_flags_t flags;
  logic oe, lim_act, log_en, fault_o;
  int errors = 0, total_checks = 0;

  brcf_ctrl_model brcf_ctrl_model_inst (.i_clk(i_clk), .i_full(full),
    .i_comp(comp), .o_pwm_hs(pwm_hs), .o_pwm_ls(pwm_ls));

  // Retry shortened so automatic retry is seen quickly
  brcf_top #(.RETRY_CYCLES(RETRY)) brcf_top_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_pwm_hs(pwm_hs), .i_pwm_ls(pwm_ls),
    .i_sleep_n_pin(sleep_n), .i_ls_diode(ls_diode),
    .i_near_zero(near_zero), .i_limit_over_ref(lim), .i_cond(cond),
    .i_sync_rectify_enable(sr_en), .i_async_rectify_enable(ar_en),
    .i_limit_recirculation_select(recir), .i_refresh_40k_sel(sel40),
    .i_pin_variant(pinv), .i_overcurrent_response_mode(ocm),
    .i_serial_error_report_sel(rep_sel),
    .i_overvolt_protect_enable(ov_en), .i_clear_faults_cmd(clear),
    .o_gate(gate), .o_flags(flags), .o_fault_out_n_o(fault_o),
    .o_fault_out_n_oe(oe), .o_limit_active(lim_act),
    .o_logic_enable(log_en));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  // ==========================================
  // Shared helpers
  task automatic chk(input string nm, input logic [7:0] exp,
      input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Lands past the edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wt

  task automatic clr();
    @(posedge i_clk);
    clear <= 1'b1;
    @(posedge i_clk);
    clear <= 1'b0;
    wt(3);
  endtask : clr

  task automatic wrise();
    int k;
    for (k = 0; k < 300 && pwm_hs[0] !== 1'b0; k++) wt(1);
    for (k = 0; k < 300 && pwm_hs[0] !== 1'b1; k++) wt(1);
    chk("pwm rise", 8'h1, {7'h0, pwm_hs[0]});
  endtask : wrise

  task automatic t_fault(input int b, input logic e_oe, input logic off,
      input string nm);
    @(posedge i_clk);
    cond[b] <= 1'b1;
    wt(6);
    chk({nm, " line"}, {7'h0, e_oe}, {7'h0, oe});
    chk({nm, " logic"}, {7'h0, b != 6}, {7'h0, log_en});
    chk({nm, " hs"}, {7'h0, !off}, {5'h0, gate.hs});
    @(posedge i_clk);
    cond[b] <= 1'b0;
    wt(6);
  endtask : t_fault

  // ==========================================
  // Scenarios
  task automatic t_auto(input int b, input int fi, input string nm);
    t_fault(b, 1'b1, 1'b1, nm);
    chk({nm, " resume"}, 8'h1, {5'h0, gate.hs});
    chk({nm, " flag"}, 8'h1, {7'h0, flags[fi]});
    clr();
    chk({nm, " flag clr"}, 8'h0, {7'h0, flags[fi]});
  endtask : t_auto

  task automatic t_ocp(input logic [1:0] m);
    @(posedge i_clk);
    ocm <= m;
    t_fault(4, m != 2'h3, m < 2'h2, "ocp");
    wt(RETRY + 10);
    chk("ocp hs after", {7'h0, m != 2'h0}, {5'h0, gate.hs});
    chk("ocp line after", {7'h0, m == 2'h0 || m == 2'h2},
      {7'h0, oe});
    chk("ocp flag", {7'h0, m != 2'h3}, {7'h0, flags[3]});
    clr();
    chk("ocp clr line", 8'h0, {7'h0, oe});
    chk("ocp clr hs", 8'h1, {5'h0, gate.hs});
  endtask : t_ocp

  task automatic t_limit(input logic rc);
    @(posedge i_clk);
    full <= 1'b0;
    recir <= rc;
    wrise();
    wt(35);
    lim <= 1'b1;
    wt(5);
    chk("lim act", 8'h1, {7'h0, lim_act});
    chk("lim hs", 8'h0, {5'h0, gate.hs});
    chk("lim ls", rc ? 8'h0 : 8'h7, {5'h0, gate.ls});
    lim <= 1'b0;
    wrise();
    wt(5);
    chk("lim rel", 8'h0, {7'h0, lim_act});
    chk("lim hs on", 8'h1, {5'h0, gate.hs});
  endtask : t_limit

  task automatic t_blank();
    int k;
    wrise();
    lim <= 1'b1;
    for (k = 0; k < 12; k++) begin
      wt(1);
      chk("blank", 8'h0, {7'h0, lim_act});
    end
    lim <= 1'b0;
    wt(6);
  endtask : t_blank

  // Two trips at full duty; releases land on refresh ticks
  task automatic t_full(input logic s40, input logic pv, input int per);
    int k, j;
    time t0;
    @(posedge i_clk);
    full <= 1'b1;
    sel40 <= s40;
    pinv <= pv;
    wt(40);
    for (j = 0; j < 2; j++) begin
      t0 = $time;
      lim <= 1'b1;
      wt(6);
      chk("full trip", 8'h1, {7'h0, lim_act});
      lim <= 1'b0;
      for (k = 0; k < 1400 && lim_act !== 1'b0; k++) wt(1);
      chk("full rel", 8'h0, {7'h0, lim_act});
    end
    k = int'(($time - t0) / 40);
    chk("refresh period", 8'h1, {7'h0, k >= per - 2 && k <= per + 2});
  endtask : t_full

  task automatic t_rect(input logic sr, input logic ar, input logic e);
    @(posedge i_clk);
    full <= 1'b0;
    sr_en <= sr;
    ar_en <= ar;
    wrise();
    wt(66);
    ls_diode <= 3'h1;
    wt(5);
    chk("diode ls", {7'h0, e}, {7'h0, gate.ls[0]});
    ls_diode <= 3'h0;
  endtask : t_rect

  task automatic t_aar();
    @(posedge i_clk);
    comp <= 1'b1;
    wrise();
    wt(66);
    chk("comp ls", 8'h1, {7'h0, gate.ls[0]});
    near_zero <= 3'h1;
    wt(5);
    chk("aar ls", 8'h0, {7'h0, gate.ls[0]});
    near_zero <= 3'h0;
    comp <= 1'b0;
  endtask : t_aar

  // Diode seen as low command ends; hold outlasts the diode
  task automatic t_cmut();
    @(posedge i_clk);
    comp <= 1'b1;
    wrise();
    wt(70);
    ls_diode <= 3'h1;
    wt(12);
    ls_diode <= 3'h0;
    wt(8);
    chk("cmut ls", 8'h1, {7'h0, gate.ls[0]});
    comp <= 1'b0;
    wt(20);
  endtask : t_cmut

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================
  // Main sequence
  initial begin
    wt(5);
    chk("rst gate", 8'h0, {2'h0, gate});
    chk("rst line", 8'h0, {7'h0, oe});
    chk("line level", 8'h0, {7'h0, fault_o});
    i_rst_n <= 1'b1;
    wt(8);
    chk("por flag", 8'h1, {7'h0, flags[5]});
    clr();
    chk("por clr", 8'h0, {7'h0, flags[5]});
    t_fault(6, 1'b0, 1'b1, "supply");
    chk("supply logic", 8'h1, {7'h0, log_en});
    chk("supply por", 8'h1, {7'h0, flags[5]});
    clr();
    t_auto(5, 4, "pump");
    t_auto(1, 1, "thermal");
    t_fault(3, 1'b1, 1'b0, "serial rep");
    clr();
    rep_sel <= 1'b1;
    t_fault(3, 1'b0, 1'b0, "serial quiet");
    clr();
    t_fault(0, 1'b0, 1'b0, "ovp off");
    t_fault(2, 1'b1, 1'b1, "trim");
    clr();
    chk("trim held", 8'h0, {5'h0, gate.hs});
    sleep_n <= 1'b0;
    wt(4);
    sleep_n <= 1'b1;
    wt(6);
    chk("trim sleep", 8'h1, {5'h0, gate.hs});
    for (int m = 0; m < 4; m++) t_ocp(2'(m));
    t_limit(1'b0);
    t_limit(1'b1);
    t_blank();
    t_full(1'b1, 1'b0, brcf_pkg::REFRESH_40K_CYC);
    t_full(1'b0, 1'b0, brcf_pkg::REFRESH_20K_CYC);
    t_full(1'b1, 1'b1, brcf_pkg::REFRESH_20K_CYC);
    t_rect(1'b1, 1'b0, 1'b0);
    t_rect(1'b1, 1'b1, 1'b1);
    t_aar();
    t_cmut();
    report_and_stop();
  end

  // Run needs about 7.5k cycles; eight times that is a hang
  initial begin
    #(40 * 60000);
    errors++;
    report_and_stop();
  end
endmodule : brcf_top_tb
`default_nettype wire
